// File: sic_pkg.sv
// Package for the step input conditioning and fault block.
// Assumes a 20 MHz system clock and a byte-addressed 32-bit register port.
package sic_pkg;

    localparam int CLK_NS = 50;

    // Minimum accepted pulse widths per filter setting, in ns
    localparam int FLT_NS [10] = '{50, 150, 200, 300, 500, 900, 1700, 3300, 6500, 12900};
    localparam int FLT_SETTINGS = 10;

    // Least time, so round up to whole cycles
    function automatic logic [8:0] sic_flt_cycles(input int ns);
        sic_flt_cycles = 9'((ns + CLK_NS - 1) / CLK_NS);
    endfunction

    localparam int SHUTDOWN_TEMP_C = 85;
    localparam logic [7:0] SHUTDOWN_TEMP = 8'(SHUTDOWN_TEMP_C);

    // Register byte offsets
    localparam logic [7:0] REG_CLK_TYPE   = 8'h00;
    localparam logic [7:0] REG_FILTER     = 8'h04;
    localparam logic [7:0] REG_EN_POL     = 8'h08;
    localparam logic [7:0] REG_WARN_TEMP  = 8'h0C;
    localparam logic [7:0] REG_FAULT      = 8'h10;
    localparam logic [7:0] REG_INT_STATUS = 8'h14;
    localparam logic [7:0] REG_INT_MASK   = 8'h18;
    localparam logic [7:0] REG_POSITION   = 8'h1C;
    localparam logic [7:0] REG_TEMP_STAT  = 8'h20;

    // Reset values
    localparam logic [1:0] RST_CLK_TYPE  = 2'h0;
    localparam logic [3:0] RST_FILTER    = 4'h0;
    localparam logic       RST_EN_POL    = 1'b1;
    localparam logic [7:0] RST_WARN_TEMP = 8'h50;

    // Fault byte bit positions
    localparam int FB_XFER_CKSUM   = 2;
    localparam int FB_SECTOR_CKSUM = 3;
    localparam int FB_DEFAULTS     = 4;
    localparam int FB_SETTINGS     = 5;
    localparam int FB_TEMP_WARN    = 6;

    // Interrupt status bit positions
    localparam int IB_FAULT    = 0;
    localparam int IB_SHUTDOWN = 1;
    localparam int IB_STEP     = 2;

    typedef enum logic [1:0] {
        SIC_STEP_DIR,
        SIC_QUAD,
        SIC_UP_DOWN
    } sic_clk_type_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sic_bus_req_t;

    typedef struct packed {
        logic xfer_cksum;
        logic sector_cksum;
        logic defaults_cksum;
        logic settings_cksum;
    } sic_err_ev_t;

endpackage

// File: sic_step_src.sv
// Step source model: the motion controller that drives the two motion pins.
// Assumes calls come right after a clock edge or clear of one.
`timescale 1ns/1ps
module sic_step_src (
    input  wire logic clk,
    output logic      motion_a,
    output logic      motion_b
);
    initial
    begin
        motion_a = 1'b0;
        motion_b = 1'b0;
    end

    // Both pins move at once; long holds model a slow controller
    task automatic put(input logic a, input logic b, input int hold);
        motion_a <= a;
        motion_b <= b;
        repeat (hold) @(posedge clk);
    endtask
endmodule

// File: sic_top.sv
// Step input conditioning: motion input decode, pulse filter, enable
// polarity, temperature warning/shutdown and sticky fault byte.
// Assumes pins are asynchronous; temperature and error events are on clk.
//
// Notes on behaviour
// - Motion pins decode as step/direction, quadrature or up/down pulses.
// - Ten selectable minimum pulse widths; narrower input pulses are rejected.
// - Enable active high by default, optionally active low.
// - Temperature at or above warning threshold sets warning bit; motor keeps running.
// - Output shuts down at or above fixed 85 C limit.
// - Fault byte ORs bits 4, 8, 16, 32, 64 for distinct errors.
// - A parameter write clears pending fault bits.
// - Fault byte is readable last; host reads after each write.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module sic_filter (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       pin,
    input  wire logic [8:0] limit,
    output logic            level
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [8:0] cnt;
        logic       out;
    } sic_flt_state_t;
    sic_flt_state_t q;
    sic_flt_state_t d;
    always_comb
    begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        if (q.s2 == q.out)
        begin
            d.cnt = 9'h000;
        end
        else if (q.cnt + 9'h001 >= limit)
        begin
            d.out = q.s2;
            d.cnt = 9'h000;
        end
        else
        begin
            d.cnt = q.cnt + 9'h001;
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end
    assign level = q.out;
    a_flt_min_width: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(q.out) |-> ($past(q.cnt) + 9'h001 >= $past(limit)))
        else $error("filtered level changed before minimum width");
endmodule

module sic_top (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 motion_a,
    input  wire logic                 motion_b,
    input  wire logic                 enable_pin,
    input  wire logic [7:0]           temp_c,
    input  wire sic_pkg::sic_err_ev_t err_ev,
    input  wire sic_pkg::sic_bus_req_t bus,
    output logic [31:0]               rd_data,
    output logic                      step_pulse,
    output logic                      step_dir,
    output logic                      motor_enable,
    output logic                      thermal_shutdown,
    output logic [7:0]                fault_byte,
    output logic                      irq
);
    typedef struct packed {
        logic [1:0]  clk_type;
        logic [3:0]  flt_sel;
        logic        en_pol;
        logic [7:0]  warn_temp;
        logic [7:0]  fault;
        logic [2:0]  int_stat;
        logic [2:0]  int_mask;
        logic [31:0] position;
        logic        en_s1;
        logic        en_s2;
        logic        a_prev;
        logic        b_prev;
        logic        step;
        logic        dir;
        logic        motor_en;
        logic        shutdown;
        logic        irq;
        logic [31:0] rdata;
    } sic_state_t;

    sic_state_t q;
    sic_state_t d;
    logic       a_flt;
    logic       b_flt;
    logic [8:0] limit;
    logic       param_wr;
    logic [7:0] fault_set;
    logic       step_ev;
    logic       dir_ev;

    always_comb
    begin
        limit = sic_pkg::sic_flt_cycles(sic_pkg::FLT_NS[0]);
        for (int i = 1; i < sic_pkg::FLT_SETTINGS; i++)
            if (q.flt_sel == 4'(i))
                limit = sic_pkg::sic_flt_cycles(sic_pkg::FLT_NS[i]);
    end

    sic_filter u_flt_a (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (motion_a),
        .limit   (limit),
        .level   (a_flt)
    );

    sic_filter u_flt_b (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (motion_b),
        .limit   (limit),
        .level   (b_flt)
    );

    assign param_wr = bus.wr && (bus.addr == sic_pkg::REG_CLK_TYPE
                      || bus.addr == sic_pkg::REG_FILTER
                      || bus.addr == sic_pkg::REG_EN_POL
                      || bus.addr == sic_pkg::REG_WARN_TEMP);

    always_comb
    begin
        fault_set = 8'h00;
        fault_set[sic_pkg::FB_XFER_CKSUM]   = err_ev.xfer_cksum;
        fault_set[sic_pkg::FB_SECTOR_CKSUM] = err_ev.sector_cksum;
        fault_set[sic_pkg::FB_DEFAULTS]     = err_ev.defaults_cksum;
        fault_set[sic_pkg::FB_SETTINGS]     = err_ev.settings_cksum;
        fault_set[sic_pkg::FB_TEMP_WARN]    = (temp_c >= q.warn_temp);
    end

    always_comb
    begin
        step_ev = 1'b0;
        dir_ev  = q.dir;
        unique case (q.clk_type)
            sic_pkg::SIC_QUAD:
            begin
                // Both edges at once carries no direction: dropped
                if ((a_flt != q.a_prev) ^ (b_flt != q.b_prev))
                begin
                    step_ev = 1'b1;
                    dir_ev  = ~(q.a_prev ^ b_flt);
                end
            end
            sic_pkg::SIC_UP_DOWN:
            begin
                if (a_flt && !q.a_prev && !(b_flt && !q.b_prev))
                begin
                    step_ev = 1'b1;
                    dir_ev  = 1'b1;
                end
                else if (b_flt && !q.b_prev && !(a_flt && !q.a_prev))
                begin
                    step_ev = 1'b1;
                    dir_ev  = 1'b0;
                end
            end
            default:
            begin
                if (a_flt && !q.a_prev)
                begin
                    step_ev = 1'b1;
                    dir_ev  = b_flt;
                end
            end
        endcase
    end

    always_comb
    begin
        d = q;
        d.en_s1  = enable_pin;
        d.en_s2  = q.en_s1;
        d.a_prev = a_flt;
        d.b_prev = b_flt;
        d.step   = step_ev;
        d.dir    = dir_ev;
        if (step_ev)
            d.position = dir_ev ? q.position + 32'h0000_0001 : q.position - 32'h0000_0001;
        d.shutdown = (temp_c >= sic_pkg::SHUTDOWN_TEMP);
        // Warning never gates the drive, only shutdown does
        d.motor_en = (q.en_s2 == q.en_pol) && !q.shutdown;
        // Set wins over the clear so an event in the write cycle survives
        d.fault = (param_wr ? 8'h00 : q.fault) | fault_set;
        if (bus.wr && bus.addr == sic_pkg::REG_INT_STATUS)
            d.int_stat = q.int_stat & ~bus.wdata[2:0];
        d.int_stat[sic_pkg::IB_FAULT]    = d.int_stat[sic_pkg::IB_FAULT]
                                           | (|(fault_set & ~q.fault));
        d.int_stat[sic_pkg::IB_SHUTDOWN] = d.int_stat[sic_pkg::IB_SHUTDOWN]
                                           | (d.shutdown & ~q.shutdown);
        d.int_stat[sic_pkg::IB_STEP]     = d.int_stat[sic_pkg::IB_STEP] | step_ev;
        d.irq = |(q.int_stat & q.int_mask);
        if (bus.wr)
        begin
            unique case (bus.addr)
                sic_pkg::REG_CLK_TYPE:
                    if (bus.wdata[1:0] != 2'h3)
                        d.clk_type = bus.wdata[1:0];
                sic_pkg::REG_FILTER:
                    // Out-of-range settings keep the old filter
                    if (bus.wdata[3:0] < 4'(sic_pkg::FLT_SETTINGS))
                        d.flt_sel = bus.wdata[3:0];
                sic_pkg::REG_EN_POL:    d.en_pol    = bus.wdata[0];
                sic_pkg::REG_WARN_TEMP: d.warn_temp = bus.wdata[7:0];
                sic_pkg::REG_INT_MASK:  d.int_mask  = bus.wdata[2:0];
                default: ;
            endcase
        end

        d.rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            unique case (bus.addr)
                sic_pkg::REG_CLK_TYPE:   d.rdata = {30'h0, q.clk_type};
                sic_pkg::REG_FILTER:     d.rdata = {28'h0, q.flt_sel};
                sic_pkg::REG_EN_POL:     d.rdata = {31'h0, q.en_pol};
                sic_pkg::REG_WARN_TEMP:  d.rdata = {24'h0, q.warn_temp};
                sic_pkg::REG_FAULT:      d.rdata = {24'h0, q.fault};
                sic_pkg::REG_INT_STATUS: d.rdata = {29'h0, q.int_stat};
                sic_pkg::REG_INT_MASK:   d.rdata = {29'h0, q.int_mask};
                sic_pkg::REG_POSITION:   d.rdata = q.position;
                sic_pkg::REG_TEMP_STAT:  d.rdata = {23'h0, q.shutdown, temp_c};
                default:                 d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            q <= '{clk_type: sic_pkg::RST_CLK_TYPE, flt_sel: sic_pkg::RST_FILTER,
                   en_pol: sic_pkg::RST_EN_POL, warn_temp: sic_pkg::RST_WARN_TEMP,
                   default: '0};
        else
            q <= d;
    end

    assign rd_data          = q.rdata;
    assign step_pulse       = q.step;
    assign step_dir         = q.dir;
    assign motor_enable     = q.motor_en;
    assign thermal_shutdown = q.shutdown;
    assign fault_byte       = q.fault;
    assign irq              = q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sd_decode: assert property (q.clk_type == sic_pkg::SIC_STEP_DIR && a_flt && !q.a_prev
        |=> q.step && q.dir == $past(b_flt)) else $error("step/direction edge not decoded");
    a_quad_double: assert property (q.clk_type == sic_pkg::SIC_QUAD && a_flt != q.a_prev
        && b_flt != q.b_prev |=> !q.step) else $error("quadrature double change produced a step");
    a_step_moves: assert property (q.step |-> q.position != $past(q.position))
        else $error("step without position change");
    a_enable_pol: assert property (
        ##1 q.motor_en == ($past(q.en_s2) == $past(q.en_pol) && !$past(q.shutdown)))
        else $error("enable polarity wrong");
    a_warn_sets: assert property (temp_c >= q.warn_temp |=> q.fault[sic_pkg::FB_TEMP_WARN])
        else $error("temperature warning not raised");
    a_warn_runs: assert property (
        temp_c < sic_pkg::SHUTDOWN_TEMP ##1 q.en_s2 == q.en_pol |=> q.motor_en)
        else $error("drive stopped below shutdown limit");
    a_shut_down: assert property (temp_c >= sic_pkg::SHUTDOWN_TEMP |=> ##1 !q.motor_en)
        else $error("no thermal shutdown");
    a_fault_sticky: assert property (
        !param_wr |=> (q.fault & $past(q.fault)) == $past(q.fault))
        else $error("fault bit dropped without parameter write");
    a_param_clear: assert property (param_wr && fault_set == 8'h00 |=> q.fault == 8'h00)
        else $error("parameter write did not clear faults");
    a_fault_read: assert property (
        bus.rd && bus.addr == sic_pkg::REG_FAULT |=> rd_data == {24'h0, $past(q.fault)})
        else $error("fault byte read mismatch");

    c_quad_step: cover property (q.clk_type == sic_pkg::SIC_QUAD && q.step);
    c_updown_down: cover property (q.clk_type == sic_pkg::SIC_UP_DOWN && q.step && !q.dir);
    c_warn_clear: cover property (q.fault[sic_pkg::FB_TEMP_WARN] ##1 param_wr);
    c_shutdown_irq: cover property (q.shutdown && q.irq);
endmodule

// File: sic_top_tb.sv
// Self-checking bench for the step input conditioning block.
// Assumes the package, design files and step source model compile first.
`timescale 1ns/1ps
module sic_top_tb;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  motion_a;
    logic                  motion_b;
    logic                  enable_pin = 1'b1;
    logic [7:0]            temp_c = 8'h14;
    sic_pkg::sic_err_ev_t  err_ev = '0;
    sic_pkg::sic_bus_req_t bus = '0;
    logic [31:0]           rd_data;
    logic                  step_pulse;
    logic                  step_dir;
    logic                  motor_enable;
    logic                  thermal_shutdown;
    logic [7:0]            fault_byte;
    logic                  irq;
    int                    n_fail = 0;
    int                    checked = 0;
    int                    seed = 35801;
    int                    n = 1;
    logic                  rd_seen = 1'b0;
    logic [31:0]           rd_q[$];
    logic                  dir_q[$];
    logic [1:0]            pst;
    logic [1:0]            nst;
    logic [7:0]            fexp;

    always #25 clk = ~clk;

    sic_step_src sic_step_src_inst (.clk(clk), .motion_a(motion_a), .motion_b(motion_b));

    sic_top sic_top_inst (
        .clk(clk), .sys_rst(sys_rst), .motion_a(motion_a), .motion_b(motion_b),
        .enable_pin(enable_pin), .temp_c(temp_c), .err_ev(err_ev), .bus(bus),
        .rd_data(rd_data), .step_pulse(step_pulse), .step_dir(step_dir),
        .motor_enable(motor_enable), .thermal_shutdown(thermal_shutdown),
        .fault_byte(fault_byte), .irq(irq)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic tick(input int c);
        // Ends on the edge: stimulus lands there, outputs read are the last edge's
        repeat (c) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask

    // Width w against filter length n decides whether a step is owed
    task automatic step_sd(input logic d, input int w);
        sic_step_src_inst.put(1'b0, d, n + 3);
        if (w >= n)
            dir_q.push_back(d);
        sic_step_src_inst.put(1'b1, d, w);
        sic_step_src_inst.put(1'b0, d, n + 3);
    endtask

    task automatic drain;
        for (int i = 0; i < 1000 && dir_q.size() > 0; i++)
            @(posedge clk);
        if (dir_q.size() > 0)
        begin
            n_fail++;
            give_verdict;
        end
        tick(n + 6);
    endtask

    // Results are matched against notes in arrival order
    always @(posedge clk)
    begin
        rd_seen <= bus.rd;
        if (rd_seen)
            check("rd_data", rd_data, rd_q.pop_front());
        if (step_pulse === 1'b1)
            check("step_dir", {31'h0, step_dir}, (dir_q.size() > 0) ? dir_q.pop_front() : 1'bx);
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        give_verdict;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(sic_pkg::REG_CLK_TYPE, 32'h0);
        rd(sic_pkg::REG_FILTER, 32'h0);
        rd(sic_pkg::REG_EN_POL, 32'h1);
        rd(sic_pkg::REG_WARN_TEMP, 32'h50);
        rd(8'h24, 32'h0);
        wr(sic_pkg::REG_CLK_TYPE, 32'h3);
        wr(sic_pkg::REG_FILTER, 32'hA);
        wr(sic_pkg::REG_FAULT, 32'hFF);
        rd(sic_pkg::REG_CLK_TYPE, 32'h0);
        rd(sic_pkg::REG_FILTER, 32'h0);
        rd(sic_pkg::REG_FAULT, 32'h0);
        tick(4);
        check("motor_enable", motor_enable, 32'h1);
        wr(sic_pkg::REG_EN_POL, 32'h0);
        tick(4);
        check("motor_enable", motor_enable, 32'h0);
        enable_pin <= 1'b0;
        tick(4);
        check("motor_enable", motor_enable, 32'h1);
        wr(sic_pkg::REG_EN_POL, 32'h1);
        enable_pin <= 1'b1;
        for (int s = 0; s < sic_pkg::FLT_SETTINGS; s++)
        begin
            wr(sic_pkg::REG_FILTER, 32'(s));
            n = (sic_pkg::FLT_NS[s] + sic_pkg::CLK_NS - 1) / sic_pkg::CLK_NS;
            step_sd(1'($random(seed)), n + 1);
            if (n > 1)
                step_sd(1'b1, n - 1);
            drain;
        end
        wr(sic_pkg::REG_FILTER, 32'h0);
        n = 1;
        sic_step_src_inst.put(1'b0, 1'b0, 4);
        wr(sic_pkg::REG_CLK_TYPE, 32'h1);
        pst = 2'b00;
        repeat (12)
        begin
            nst = pst ^ ((1'($random(seed))) ? 2'b10 : 2'b01);
            dir_q.push_back(~(pst[1] ^ nst[0]));
            sic_step_src_inst.put(nst[1], nst[0], 4);
            pst = nst;
        end
        // Both pins at once carry no step
        sic_step_src_inst.put(~pst[1], ~pst[0], 4);
        drain;
        sic_step_src_inst.put(1'b0, 1'b0, 4);
        wr(sic_pkg::REG_CLK_TYPE, 32'h2);
        repeat (6)
        begin
            pst[0] = 1'($random(seed));
            dir_q.push_back(pst[0]);
            sic_step_src_inst.put(pst[0], ~pst[0], 4);
            sic_step_src_inst.put(1'b0, 1'b0, 4);
        end
        sic_step_src_inst.put(1'b1, 1'b1, 4);
        sic_step_src_inst.put(1'b0, 1'b0, 4);
        drain;
        fexp = 8'h0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            err_ev <= 4'(1 << k);
            @(posedge clk);
            err_ev <= '0;
            fexp = fexp | 8'(1 << (sic_pkg::FB_SETTINGS - k));
            tick(1);
            check("fault_byte", fault_byte, fexp);
        end
        tick(20);
        check("fault_byte", fault_byte, fexp);
        rd(sic_pkg::REG_FAULT, {24'h0, fexp});
        check("irq", irq, 32'h0);
        wr(sic_pkg::REG_INT_MASK, 32'h1);
        tick(2);
        check("irq", irq, 32'h1);
        wr(sic_pkg::REG_INT_STATUS, 32'h1);
        tick(2);
        check("irq", irq, 32'h0);
        rd(sic_pkg::REG_INT_MASK, 32'h1);
        wr(sic_pkg::REG_WARN_TEMP, 32'h30);
        rd(sic_pkg::REG_FAULT, 32'h0);
        temp_c <= 8'($random(seed)) & 8'h2F;
        tick(3);
        check("fault_byte", fault_byte, 32'h0);
        temp_c <= 8'h30;
        tick(3);
        check("fault_byte", fault_byte, 32'h40);
        check("motor_enable", motor_enable, 32'h1);
        temp_c <= sic_pkg::SHUTDOWN_TEMP - 8'h1;
        tick(3);
        check("thermal_shutdown", thermal_shutdown, 32'h0);
        temp_c <= sic_pkg::SHUTDOWN_TEMP;
        tick(3);
        check("thermal_shutdown", thermal_shutdown, 32'h1);
        check("motor_enable", motor_enable, 32'h0);
        temp_c <= 8'h14;
        tick(3);
        check("fault_byte", fault_byte, 32'h40);
        wr(sic_pkg::REG_FILTER, 32'h0);
        tick(1);
        check("fault_byte", fault_byte, 32'h0);
        tick(4);
        give_verdict;
    end
endmodule
